// file: core/ebtz_timer.sv
// 8-bit timer 0 with APB register access
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "ebtz_defs.svh"
// ----------------------------------------------------------------
// Notes on behaviour
// R1 - an 8-bit up-counter compared against an 8-bit reference value
// R2 - control register selects interval, capture or pulse width modes
// R3 - interval mode toggles the toggle output on every match
// R4 - capture mode fires on a configured rising or falling capture edge
// R5 - match request forwarded only while match enable bit 7 is one
// R6 - match flag bit 7 set on match, cleared when serviced
// R7 - overflow request forwarded only while overflow enable bit 6 is one
// R8 - overflow flag bit 6 set on overflow, cleared when serviced
// R9 - clock select 0101 counts rising edges of the external count input
// R10 - clock select 0110 counts falling edges of the external count input
// R11 - clock select 0111 counts on the sub clock
// R12 - software sets counter clear after writing the reference data
// R13 - counter is compared with a buffer copy of the reference
// R14 - buffer reloads on counter clear, overflow flag and match flag
// R15 - 0000 stops, 0001-0100 reserved, 1xxx divide system clock 2..2048
// R16 - counter clear zeroes the counter and returns to zero itself
// ----------------------------------------------------------------
module ebtz_timer
  import ebtz_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic sub_clock,
  input wire logic capture_input_pin,
  input wire logic svc_match,
  input wire logic svc_ovf,
  output logic toggle_output_pin,
  output logic pwm_output_pin,
  output logic match_irq_q,
  output logic overflow_irq_q,
  output logic irq
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic ec_s1_q, ec_s2_q, ec_s3_q;
  logic sub_s1_q, sub_s2_q, sub_s3_q;
  logic cap_s1_q, cap_s2_q, cap_s3_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {ec_s1_q, ec_s2_q, ec_s3_q} <= 3'h0;
      {sub_s1_q, sub_s2_q, sub_s3_q} <= 3'h0;
      {cap_s1_q, cap_s2_q, cap_s3_q} <= 3'h0;
    end else begin
      {ec_s1_q, ec_s2_q, ec_s3_q} <= {external_count_input, ec_s1_q, ec_s2_q};
      {sub_s1_q, sub_s2_q, sub_s3_q} <= {sub_clock, sub_s1_q, sub_s2_q};
      {cap_s1_q, cap_s2_q, cap_s3_q} <= {capture_input_pin, cap_s1_q, cap_s2_q};
    end
  end

  wire ec_rise = ec_s2_q & ~ec_s3_q;
  wire ec_fall = ~ec_s2_q & ec_s3_q;
  wire sub_rise = sub_s2_q & ~sub_s3_q;
  wire cap_rise = cap_s2_q & ~cap_s3_q;
  wire cap_fall = ~cap_s2_q & cap_s3_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  ebtz_byte_t ctrl_q;
  ebtz_byte_t ref_q;
  ebtz_byte_t buf_q;
  ebtz_byte_t cnt_q;
  ebtz_byte_t cnt_d;
  logic [1:0] ien_q;
  logic [1:0] req_q;
  logic [1:0] req_d;
  logic cap_fall_q;
  logic clr_q;
  logic pready_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready_q & pwrite;
  wire hit_ctrl = (paddr == `EBTZ_CTRL_OFS);
  wire hit_ref = (paddr == `EBTZ_REF_OFS);
  wire hit_cnt = (paddr == `EBTZ_CNT_OFS);
  wire hit_ien = (paddr == `EBTZ_IEN_OFS);
  wire hit_irq = (paddr == `EBTZ_IRQ_OFS);
  wire hit_cap = (paddr == `EBTZ_CAP_OFS);
  wire mapped = hit_ctrl | hit_ref | hit_cnt | hit_ien | hit_irq | hit_cap;
  wire wr_ctrl = wr_en & hit_ctrl;
  wire wr_ref = wr_en & hit_ref;
  wire wr_ien = wr_en & hit_ien;
  wire wr_irq = wr_en & hit_irq;
  wire wr_cap = wr_en & hit_cap;
  wire [1:0] req_pair = {pwdata[`EBTZ_MIR_BIT], pwdata[`EBTZ_OVR_BIT]};

  function automatic ebtz_byte_t hi_pair(input logic [1:0] p);
    return {p, 6'h00};
  endfunction

  wire [7:0] rd_byte =
    hit_ctrl ? ctrl_q :
    hit_ref ? ref_q :
    hit_cnt ? cnt_q :
    hit_ien ? hi_pair(ien_q) :
    hit_irq ? hi_pair(req_q) :
    hit_cap ? {7'h00, cap_fall_q} : 8'h00;

  // zero-wait slave: pready rises in the first access cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata <= {24'h000000, rd_byte};
        pslverr <= ~mapped;
      end
    end
  end

  assign pready = pready_q;

  // ----------------------------------------------------------------
  // mode and count clock selection
  // ----------------------------------------------------------------
  wire [3:0] cs = ctrl_q[`EBTZ_CS_HI:0];
  wire [1:0] ms = ctrl_q[`EBTZ_MS_HI:`EBTZ_MS_LO];
  wire is_pwm = (ms == EBTZ_PWM); // [R2]
  wire is_cap = ms[1]; // [R2]
  wire is_int = (ms == EBTZ_INTERVAL); // [R2]
  wire pre_tick;

  ebtz_prescale u_pre (
    .clk(clk),
    .rstn(rstn),
    .div_sel(cs[2:0]),
    .tick_q(pre_tick)
  ); // [R15]

  // reserved codes behave as stop
  wire tick =
    (cs == `EBTZ_CS_EC_RISE) ? ec_rise : // [R9]
    (cs == `EBTZ_CS_EC_FALL) ? ec_fall : // [R10]
    (cs == `EBTZ_CS_SUB) ? sub_rise : // [R11]
    cs[3] ? pre_tick : 1'b0; // [R15]

  // ----------------------------------------------------------------
  // counter events
  // ----------------------------------------------------------------
  wire at_match = (cnt_q == buf_q); // [R13]
  wire at_top = (cnt_q == `EBTZ_CNT_MAX);
  wire cap_ev = is_cap & (cap_fall_q ? cap_fall : cap_rise); // [R4]
  wire match_ev = tick & ~is_cap & at_match & ~clr_q & ~cap_ev; // [R1]
  wire ovf_ev = tick & at_top & ~clr_q & ~cap_ev & ~(is_int & at_match);
  wire buf_load = clr_q | ovf_ev | match_ev; // [R14]

  always_comb begin
    cnt_d = cnt_q;
    if (clr_q || cap_ev) begin
      cnt_d = 8'h00; // [R16]
    end else if (match_ev && is_int) begin
      cnt_d = 8'h00;
    end else if (tick) begin
      cnt_d = cnt_q + 8'h01; // [R1]
    end
  end

  // a flag set by hardware wins over a service or a one-write
  wire [1:0] req_set = {match_ev, ovf_ev}; // [R6] [R8]
  wire [1:0] req_clr = ({svc_match, svc_ovf} | ({2{wr_irq}} & req_pair));
  assign req_d = req_set | (req_q & ~req_clr);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `EBTZ_CTRL_RST;
      clr_q <= 1'b0;
    end else begin
      // clear bit never stored, it reads back zero
      if (wr_ctrl) begin
        ctrl_q <= pwdata[7:0] & ~(8'h01 << `EBTZ_CC_BIT);
      end
      clr_q <= wr_ctrl & pwdata[`EBTZ_CC_BIT]; // [R16]
    end
  end

  // a register write outranks a capture landing in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_q <= `EBTZ_BYTE_RST;
    end else if (wr_ref) begin
      ref_q <= pwdata[7:0];
    end else if (cap_ev) begin
      ref_q <= cnt_q; // [R4]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_q <= `EBTZ_BYTE_RST;
      cnt_q <= `EBTZ_BYTE_RST;
    end else begin
      if (buf_load) begin
        buf_q <= ref_q; // [R14]
      end
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ien_q <= 2'h0;
      req_q <= 2'h0;
      cap_fall_q <= 1'b0;
    end else begin
      if (wr_ien) begin
        ien_q <= req_pair;
      end
      if (wr_cap) begin
        cap_fall_q <= pwdata[`EBTZ_CAP_FALL_BIT];
      end
      req_q <= req_d;
    end
  end

  // ----------------------------------------------------------------
  // pins and interrupt outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      toggle_output_pin <= 1'b0;
      pwm_output_pin <= 1'b0;
      match_irq_q <= 1'b0;
      overflow_irq_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (match_ev && is_int) begin
        toggle_output_pin <= ~toggle_output_pin; // [R3]
      end
      // high while the buffer copy of the reference exceeds the count
      pwm_output_pin <= is_pwm & (buf_q > cnt_q); // [R2]
      match_irq_q <= req_q[1] & ien_q[1]; // [R5]
      overflow_irq_q <= req_q[0] & ien_q[0]; // [R7]
      irq <= |(req_q & ien_q);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_cc_write;
    wr_ctrl && pwdata[`EBTZ_CC_BIT];
  endsequence

  sequence s_clear_done;
    clr_q ##1 (cnt_q == 8'h00 && !clr_q && !ctrl_q[`EBTZ_CC_BIT]);
  endsequence

  sequence s_flag_set(bit f);
    f ##1 1'b1;
  endsequence

  a_clear_bit_self: assert property ( // [R16]
    s_cc_write |=> s_clear_done
  ) else $error("counter clear did not zero the counter");

  a_count_step: assert property ( // [R1]
    tick && !clr_q && !cap_ev && !match_ev |=> cnt_q == $past(cnt_q) + 8'h01
  ) else $error("counter did not advance on a tick");

  a_stop_hold: assert property ( // [R15]
    (cs == `EBTZ_CS_STOP || cs == 4'h1) && !clr_q && !cap_ev |=> $stable(cnt_q)
  ) else $error("stopped counter moved");

  a_ec_rise_cnt: assert property ( // [R9]
    cs == `EBTZ_CS_EC_RISE && !ec_rise && !clr_q && !cap_ev |=> $stable(cnt_q)
  ) else $error("counted without an external rising edge");

  a_ec_fall_cnt: assert property ( // [R10]
    cs == `EBTZ_CS_EC_FALL && !ec_fall && !clr_q && !cap_ev |=> $stable(cnt_q)
  ) else $error("counted without an external falling edge");

  a_sub_cnt: assert property ( // [R11]
    cs == `EBTZ_CS_SUB && !sub_rise && !clr_q && !cap_ev |=> $stable(cnt_q)
  ) else $error("counted without a sub clock edge");

  a_match_toggle: assert property ( // [R3]
    is_int && match_ev |=> toggle_output_pin != $past(toggle_output_pin) && cnt_q == 8'h00
  ) else $error("interval match did not toggle and restart");

  a_capture_load: assert property ( // [R4]
    cap_ev && !wr_ref |=> ref_q == $past(cnt_q) && cnt_q == 8'h00
  ) else $error("capture did not load the reference");

  a_buf_copy: assert property ( // [R14]
    buf_load |=> buf_q == $past(ref_q)
  ) else $error("buffer not reloaded from the reference");

  a_buf_hold: assert property ( // [R13]
    !buf_load |=> $stable(buf_q)
  ) else $error("compare buffer changed without a reload event");

  a_match_flag: assert property ( // [R6]
    s_flag_set(match_ev) |-> req_q[1] ##1 (match_irq_q == ien_q[1] || $changed(ien_q))
  ) else $error("match flag or request wrong");

  a_ovf_flag: assert property ( // [R8]
    ovf_ev |=> req_q[0]
  ) else $error("overflow flag not set");

  a_match_fwd: assert property ( // [R5]
    !ien_q[1] |=> !match_irq_q
  ) else $error("match request forwarded while disabled");

  a_ovf_fwd: assert property ( // [R7]
    req_q[0] && ien_q[0] |=> overflow_irq_q && irq
  ) else $error("overflow request not forwarded");

  a_pwm_level: assert property ( // [R2]
    is_pwm |=> pwm_output_pin == ($past(buf_q) > $past(cnt_q))
  ) else $error("pwm level does not follow the compare");

  a_match_on: assert property ( // [R5]
    req_q[1] && ien_q[1] |=> match_irq_q && irq
  ) else $error("match request not forwarded");

  a_clear_unstored: assert property ( // [R16]
    !ctrl_q[`EBTZ_CC_BIT]
  ) else $error("counter clear bit was stored");
endmodule

// file: core/ebtz_defs.svh
// register offsets, field positions and codes of the 8-bit timer 0
`ifndef EBTZ_DEFS_SVH
`define EBTZ_DEFS_SVH
`define EBTZ_CTRL_OFS 8'hb0
`define EBTZ_REF_OFS 8'hb4
`define EBTZ_CNT_OFS 8'hb8
`define EBTZ_IEN_OFS 8'hbc
`define EBTZ_IRQ_OFS 8'hc0
`define EBTZ_CAP_OFS 8'hc4
`define EBTZ_CTRL_RST 8'h00
`define EBTZ_BYTE_RST 8'h00
`define EBTZ_WID_BIT 7
`define EBTZ_MS_HI 6
`define EBTZ_MS_LO 5
`define EBTZ_CC_BIT 4
`define EBTZ_CS_HI 3
`define EBTZ_MIR_BIT 7
`define EBTZ_OVR_BIT 6
`define EBTZ_CAP_FALL_BIT 0
`define EBTZ_CS_STOP 4'h0
`define EBTZ_CS_EC_RISE 4'h5
`define EBTZ_CS_EC_FALL 4'h6
`define EBTZ_CS_SUB 4'h7
`define EBTZ_CNT_MAX 8'hff
`endif

// file: core/ebtz_pkg.sv
// types shared by the timer 0 files
package ebtz_pkg;
  typedef logic [7:0] ebtz_byte_t;
  typedef enum logic [1:0] {
    EBTZ_INTERVAL = 2'h0,
    EBTZ_PWM = 2'h1,
    EBTZ_CAPTURE = 2'h2
  } ebtz_mode_e;
endpackage

// file: core/ebtz_prescale.sv
// system clock prescaler giving one-cycle count ticks
`timescale 1ns/1ps
module ebtz_prescale
  import ebtz_pkg::*;
#(
  parameter int DW = 11
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] div_sel,
  output logic tick_q
);
  logic [DW-1:0] div_q;
  wire [DW-1:0] div_mask;

  // divide by 2,4,8,16,32,128,512,2048
  function automatic logic [DW-1:0] mask_of(input logic [2:0] s);
    logic [DW-1:0] m;
    m = '0;
    case (s)
      3'h0: m = 11'h001;
      3'h1: m = 11'h003;
      3'h2: m = 11'h007;
      3'h3: m = 11'h00f;
      3'h4: m = 11'h01f;
      3'h5: m = 11'h07f;
      3'h6: m = 11'h1ff;
      default: m = 11'h7ff;
    endcase
    return m;
  endfunction

  assign div_mask = mask_of(div_sel);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_q + 11'h001;
      tick_q <= ((div_q & div_mask) == div_mask);
    end
  end
endmodule

// file: dv/ebtz_timer_bench.sv
// self-checking bench for the 8-bit timer 0 with its APB registers
`timescale 1ns/1ps
`include "ebtz_defs.svh"
`define CHK(nm, ex, got) check_count++; if ((got) !== (ex)) begin $display("wrong value %s exp %h got %h", nm, ex, got); errors++; end
module ebtz_timer_bench;
  import ebtz_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, ext = 0, sub = 0, cap = 0, svc_m = 0, svc_o = 0;
  logic tog, pwm, mirq, oirq, irq;
  int errors = 0, check_count = 0, hi;
  int divs[8] = '{2, 4, 8, 16, 32, 128, 512, 2048};
  always #2.5 clk = ~clk;
  ebtz_timer ebtz_timer_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_input(ext), .sub_clock(sub),
    .capture_input_pin(cap), .svc_match(svc_m), .svc_ovf(svc_o),
    .toggle_output_pin(tog), .pwm_output_pin(pwm), .match_irq_q(mirq),
    .overflow_irq_q(oirq), .irq(irq));
  // ----------------------------------------------------------------
  // bus and pin helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // master waits for pready with no fixed latency assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      errors++;
      close_out();
    end
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 8'h00);
    `CHK(nm, ex, rd)
  endtask
  task automatic pulse_ext(input int n);
    repeat (n) begin
      @(posedge clk) ext <= 1'b1;
      repeat (4) @(posedge clk);
      ext <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  // pin codes: 0 external count, 1 sub clock, 2 capture
  task automatic set_pin(input int pin, input logic v);
    @(posedge clk);
    if (pin == 0) ext <= v;
    else if (pin == 1) sub <= v;
    else cap <= v;
    repeat (6) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk("ctrl reset", `EBTZ_CTRL_OFS, 32'h0);
    `CHK("mapped err", 1'b0, er)
    apb(1'b0, 8'hd0, 8'h00);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    $display("test reset done");
  endtask
  task automatic t_ext();
    apb(1'b1, `EBTZ_REF_OFS, 8'h03);
    apb(1'b1, `EBTZ_IEN_OFS, 8'h00);
    apb(1'b1, `EBTZ_CTRL_OFS, 8'h15);
    rdchk("clear self", `EBTZ_CTRL_OFS, 32'h05);
    apb(1'b1, `EBTZ_REF_OFS, 8'h06);
    // a match needs the tick that finds the count equal, so reference plus one ticks
    pulse_ext(4);
    rdchk("match buf", `EBTZ_IRQ_OFS, 32'h80);
    `CHK("masked irq", 2'b00, {mirq, irq})
    `CHK("toggle", 1'b1, tog)
    rdchk("cnt at match", `EBTZ_CNT_OFS, 32'h0);
    apb(1'b1, `EBTZ_IRQ_OFS, 8'h80);
    pulse_ext(5);
    rdchk("no match 5", `EBTZ_IRQ_OFS, 32'h0);
    rdchk("cnt 5", `EBTZ_CNT_OFS, 32'h5);
    pulse_ext(2);
    rdchk("reload match", `EBTZ_IRQ_OFS, 32'h80);
    `CHK("toggle back", 1'b0, tog)
    apb(1'b1, `EBTZ_IRQ_OFS, 8'h80);
    $display("test ext done");
  endtask
  task automatic t_clk();
    apb(1'b1, `EBTZ_CTRL_OFS, 8'h16);
    set_pin(0, 1'b1);
    rdchk("no rise cnt", `EBTZ_CNT_OFS, 32'h0);
    set_pin(0, 1'b0);
    rdchk("fall cnt", `EBTZ_CNT_OFS, 32'h1);
    apb(1'b1, `EBTZ_CTRL_OFS, 8'h17);
    repeat (2) begin
      set_pin(1, 1'b1);
      set_pin(1, 1'b0);
    end
    rdchk("sub cnt", `EBTZ_CNT_OFS, 32'h2);
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, `EBTZ_CTRL_OFS, 8'h10 | c[7:0]);
      pulse_ext(1);
      set_pin(1, 1'b1);
      set_pin(1, 1'b0);
      rdchk("stopped cnt", `EBTZ_CNT_OFS, 32'h0);
    end
    apb(1'b1, `EBTZ_REF_OFS, 8'hff);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `EBTZ_CTRL_OFS, 8'h18 + c[7:0]);
      repeat (8 * divs[c]) @(posedge clk);
      apb(1'b0, `EBTZ_CNT_OFS, 8'h00);
      hi = 9 + 12 / divs[c];
      `CHK("div cnt", 1'b1, (rd >= 7 && rd <= hi))
    end
    $display("test clocks done");
  endtask
  task automatic t_ovf();
    int n;
    apb(1'b1, `EBTZ_REF_OFS, 8'h10);
    apb(1'b1, `EBTZ_IEN_OFS, 8'hc0);
    apb(1'b1, `EBTZ_CTRL_OFS, 8'h38);
    for (n = 0; n < 700 && oirq !== 1'b1; n++) @(posedge clk);
    if (n == 700) begin
      errors++;
      close_out();
    end
    `CHK("ovf irq", 1'b1, oirq)
    `CHK("pwm high", 1'b1, pwm)
    `CHK("irq out", 1'b1, irq)
    `CHK("match irq", 1'b1, mirq)
    apb(1'b1, `EBTZ_CTRL_OFS, 8'h20);
    @(posedge clk) svc_o <= 1'b1;
    @(posedge clk) svc_o <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("ovf svc", 1'b0, oirq)
    @(posedge clk) svc_m <= 1'b1;
    @(posedge clk) svc_m <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("irq cleared", 2'b00, {mirq, irq})
    rdchk("flags clear", `EBTZ_IRQ_OFS, 32'h0);
    apb(1'b1, `EBTZ_IEN_OFS, 8'h40);
    apb(1'b1, `EBTZ_IRQ_OFS, 8'h00);
    `CHK("ovf en only", 1'b0, mirq)
    $display("test ovf done");
  endtask
  task automatic t_cap();
    apb(1'b1, `EBTZ_CAP_OFS, 8'h00);
    apb(1'b1, `EBTZ_CTRL_OFS, 8'h55);
    pulse_ext(2);
    set_pin(2, 1'b1);
    rdchk("cap rise", `EBTZ_REF_OFS, 32'h2);
    rdchk("cap clr", `EBTZ_CNT_OFS, 32'h0);
    apb(1'b1, `EBTZ_CAP_OFS, 8'h01);
    pulse_ext(3);
    set_pin(2, 1'b0);
    rdchk("cap fall", `EBTZ_REF_OFS, 32'h3);
    $display("test capture done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_ext();
    t_clk();
    t_ovf();
    t_cap();
    close_out();
  end
endmodule
